// ===== src/selftest_defines.svh
`ifndef SELFTEST_DEFINES_SVH
`define SELFTEST_DEFINES_SVH
// Overview of operation
// [RULE1] self-test starts by itself after every reset release, no host action.
// [RULE2] fault indicator lit throughout the whole self-test sequence.
// [RULE3] chip phase lasts about 6 s; pass with no disc phase turns indicator off.
// [RULE4] disc present adds a 5 s read/write phase, about 11 s total. Code skips the disc phase after a failed chip phase.
// [RULE5] any detected error keeps the indicator lit after the test time.
// [RULE6] write-protected disc skips the disc phase; only the chip phase runs.
// [RULE7] chip phase checks loop chip, disc controller, RAM, ROM, interface adapter.
// [RULE8] disc phase writes then reads track 79, only with initialized disc present.
// [RULE9] host disc commands are held off until the result is shown.

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ST_CLK_HZ 50000000
`define ST_CHIP_PHASE_S 6
`define ST_DISC_PHASE_S 5
// ------------------------------------------------------------
// chip test sequence
// ------------------------------------------------------------
`define ST_NUM_CHIPS 5
`define ST_CHIP_IDX_W 3
`define ST_CHIP_LOOP 3'h0
`define ST_CHIP_DISC_CTRL 3'h1
`define ST_CHIP_RAM 3'h2
`define ST_CHIP_ROM 3'h3
`define ST_CHIP_ADAPTER 3'h4
`define ST_SYSTEM_TRACK 7'h4F
`endif

// ===== src/selftest_pkg.sv
package selftest_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHIP = 3'h1,
    ST_WRITE = 3'h3,
    ST_READ = 3'h2,
    ST_HOLD = 3'h6,
    ST_DONE = 3'h7
  } st_state_t;

  // request to a unit under test and its answer
  typedef struct packed {
    logic valid;
    logic [2:0] unit;
  } chip_req_t;

  typedef struct packed {
    logic done;
    logic pass;
  } unit_rsp_t;

  typedef struct packed {
    logic present;
    logic initialized;
    logic write_prot;
  } disc_stat_t;

  typedef struct packed {
    logic write_req;
    logic read_req;
    logic [6:0] track;
  } disc_req_t;
endpackage : selftest_pkg

// ===== src/selftest_timer.sv
`timescale 1ns/1ps
`include "selftest_defines.svh"
module selftest_timer
  import selftest_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_len,
  output logic o_expired
);
  logic [CNT_W-1:0] cnt_reg;
  logic run_reg;
  logic exp_reg;
  wire at_end = run_reg && (cnt_reg == i_len - {{(CNT_W-1){1'b0}}, 1'b1});

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
      exp_reg <= 1'b0;
    end else if (at_end) begin
      run_reg <= 1'b0;
      exp_reg <= 1'b1;
    end else begin
      cnt_reg <= run_reg ? cnt_reg + 1'b1 : cnt_reg;
      exp_reg <= 1'b0;
    end
  end

  assign o_expired = exp_reg;
endmodule : selftest_timer

// ===== src/power_on_selftest_sequencer.sv
`timescale 1ns/1ps
`include "selftest_defines.svh"
module power_on_selftest_sequencer
  import selftest_pkg::*;
#(
  parameter int CLK_HZ = `ST_CLK_HZ,
  parameter int CHIP_PHASE_CYC = `ST_CHIP_PHASE_S * CLK_HZ,
  parameter int DISC_PHASE_CYC = `ST_DISC_PHASE_S * CLK_HZ
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire disc_stat_t i_disc_stat,
  input wire unit_rsp_t i_chip_rsp,
  input wire unit_rsp_t i_disc_rsp,
  output chip_req_t o_chip_req,
  output disc_req_t o_disc_req,
  output logic o_fault_led,
  output logic o_selftest_busy,
  output logic o_selftest_failed,
  output logic o_host_cmd_enable
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  disc_stat_t disc_meta_reg;
  disc_stat_t disc_sync_reg;
  unit_rsp_t chip_meta_reg;
  unit_rsp_t chip_sync_reg;
  unit_rsp_t dsk_meta_reg;
  unit_rsp_t dsk_sync_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      disc_meta_reg <= '0;
      disc_sync_reg <= '0;
      chip_meta_reg <= '0;
      chip_sync_reg <= '0;
      dsk_meta_reg <= '0;
      dsk_sync_reg <= '0;
    end else begin
      disc_meta_reg <= i_disc_stat;
      disc_sync_reg <= disc_meta_reg;
      chip_meta_reg <= i_chip_rsp;
      chip_sync_reg <= chip_meta_reg;
      dsk_meta_reg <= i_disc_rsp;
      dsk_sync_reg <= dsk_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  st_state_t state_reg;
  st_state_t state_next;
  logic [`ST_CHIP_IDX_W-1:0] unit_reg;
  logic [`ST_CHIP_IDX_W-1:0] unit_next;
  logic fail_reg;
  logic fail_next;
  logic chips_done_reg;
  logic chips_done_next;
  logic disc_phase_reg;
  logic disc_phase_next;
  logic req_valid_reg;
  logic req_valid_next;
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic led_reg;
  logic busy_reg;
  logic host_en_reg;
  logic tmr_start;
  logic [31:0] tmr_len;
  logic tmr_expired;

  // disc phase only for a present, initialized, writable disc
  wire disc_ok = disc_sync_reg.present && disc_sync_reg.initialized
                 && !disc_sync_reg.write_prot; // RULE6 RULE8
  wire last_unit = (unit_reg == 3'(`ST_NUM_CHIPS - 1));
  wire chip_ans = chip_sync_reg.done && !req_valid_reg;
  wire disc_ans = dsk_sync_reg.done && !wr_reg && !rd_reg;

  selftest_timer #(
    .CNT_W(32)
  ) u_phase_timer (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_start(tmr_start),
    .i_len(tmr_len),
    .o_expired(tmr_expired)
  );

  // the timer compares against its length every cycle, so the length
  // follows the phase flag, not the state, which leaves idle at once
  assign tmr_len = disc_phase_reg ? 32'(DISC_PHASE_CYC) : 32'(CHIP_PHASE_CYC);

  // phases are paced by the timer so the indicator time is fixed even
  // when the units answer quickly; a unit that never answers is a failure
  always_comb begin
    state_next = state_reg;
    unit_next = unit_reg;
    fail_next = fail_reg;
    chips_done_next = chips_done_reg;
    disc_phase_next = disc_phase_reg;
    req_valid_next = 1'b0;
    wr_next = 1'b0;
    rd_next = 1'b0;
    tmr_start = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // runs straight out of reset, nothing from the host needed
        state_next = ST_CHIP; // RULE1
        tmr_start = 1'b1; // RULE3
        unit_next = `ST_CHIP_LOOP;
        req_valid_next = 1'b1;
      end
      ST_CHIP: begin
        // units in turn: loop chip, disc controller, RAM, ROM, adapter
        if (chip_ans && !chips_done_reg) begin // RULE7
          if (!chip_sync_reg.pass) begin
            fail_next = 1'b1; // RULE5
          end
          if (last_unit) begin
            chips_done_next = 1'b1;
          end else begin
            unit_next = unit_reg + 3'h1;
            req_valid_next = 1'b1;
          end
        end
        if (tmr_expired) begin
          if (!chips_done_reg && !(chip_ans && last_unit)) begin
            fail_next = 1'b1; // RULE5
          end
          // disc is judged at phase end; a failed chip phase skips it
          if (disc_ok && !fail_next) begin // RULE4 RULE6 RULE8
            state_next = ST_WRITE;
            disc_phase_next = 1'b1;
            tmr_start = 1'b1;
            wr_next = 1'b1;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_WRITE: begin
        if (disc_ans) begin // RULE8
          if (!dsk_sync_reg.pass) begin
            fail_next = 1'b1;
            state_next = ST_HOLD;
          end else begin
            rd_next = 1'b1;
            state_next = ST_READ;
          end
        end else if (tmr_expired) begin
          fail_next = 1'b1;
          state_next = ST_DONE;
        end
      end
      ST_READ: begin
        if (disc_ans) begin
          fail_next = fail_reg | !dsk_sync_reg.pass; // RULE5
          state_next = ST_HOLD;
        end else if (tmr_expired) begin
          fail_next = 1'b1;
          state_next = ST_DONE;
        end
      end
      ST_HOLD: begin
        // wait out the disc phase so the total time stays about 11 s
        if (tmr_expired) begin // RULE4
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      unit_reg <= '0;
      fail_reg <= 1'b0;
      chips_done_reg <= 1'b0;
      disc_phase_reg <= 1'b0;
      req_valid_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      unit_reg <= unit_next;
      fail_reg <= fail_next;
      chips_done_reg <= chips_done_next;
      disc_phase_reg <= disc_phase_next;
      req_valid_reg <= req_valid_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // ------------------------------------------------------------
  // indicator and host gating
  // ------------------------------------------------------------
  wire done_next = (state_next == ST_DONE);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      led_reg <= 1'b1; // RULE2
      busy_reg <= 1'b1;
      host_en_reg <= 1'b0;
    end else begin
      // lit while running, and stays lit on failure
      led_reg <= !done_next || fail_next; // RULE2 RULE3 RULE5
      busy_reg <= !done_next;
      host_en_reg <= done_next; // RULE9
    end
  end

  assign o_chip_req = '{valid: req_valid_reg, unit: unit_reg};
  assign o_disc_req = '{write_req: wr_reg, read_req: rd_reg, track: `ST_SYSTEM_TRACK};
  assign o_fault_led = led_reg;
  assign o_selftest_busy = busy_reg;
  assign o_selftest_failed = fail_reg;
  assign o_host_cmd_enable = host_en_reg;
endmodule : power_on_selftest_sequencer

// ===== testbench/selftest_sva.sv
`timescale 1ns/1ps
module selftest_sva
  import selftest_pkg::*;
#(
  parameter int CHIP_PHASE_CYC = 200,
  parameter int DISC_PHASE_CYC = 150
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire disc_stat_t i_disc_stat,
  input wire chip_req_t o_chip_req,
  input wire disc_req_t o_disc_req,
  input wire logic o_fault_led,
  input wire logic o_selftest_busy,
  input wire logic o_selftest_failed,
  input wire logic o_host_cmd_enable
);
  // ----
  // busy length and disc phase seen since reset
  // ----
  int busy_cnt;
  logic wr_seen;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      busy_cnt <= 0;
      wr_seen <= 1'b0;
    end else begin
      busy_cnt <= busy_cnt + int'(o_selftest_busy);
      wr_seen <= wr_seen | o_disc_req.write_req;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  led_busy_a: assert property (o_selftest_busy |-> o_fault_led)
    else $error("led dark while busy");
  host_hold_a: assert property (o_selftest_busy |-> !o_host_cmd_enable)
    else $error("host enabled while busy");
  auto_start_a: assert property ($rose(i_nrst) |-> ##[0:2] o_chip_req.valid)
    else $error("no start after reset");
  track_fixed_a: assert property ((o_disc_req.write_req || o_disc_req.read_req)
    |-> o_disc_req.track == 7'h4F) else $error("wrong track");
  read_after_write_a: assert property (o_disc_req.read_req |-> wr_seen)
    else $error("read before write");
  disc_gate_a: assert property (o_disc_req.write_req |-> i_disc_stat == 3'h6
    && !o_selftest_failed) else $error("disc phase not allowed");
  result_shown_a: assert property ($fell(o_selftest_busy) |-> o_host_cmd_enable
    && o_fault_led == o_selftest_failed) else $error("result mismatch");
  chip_time_a: assert property ($fell(o_selftest_busy) |-> busy_cnt >= CHIP_PHASE_CYC)
    else $error("chip phase short");
  disc_time_a: assert property ($fell(o_selftest_busy) && wr_seen
    |-> busy_cnt >= CHIP_PHASE_CYC + DISC_PHASE_CYC) else $error("disc phase short");
  max_time_a: assert property (o_selftest_busy |->
    busy_cnt < CHIP_PHASE_CYC + DISC_PHASE_CYC + 32) else $error("sequence too long");
  fail_sticky_a: assert property (o_selftest_failed |=> o_selftest_failed)
    else $error("failure flag lost");
  cover property (o_disc_req.read_req);
  cover property ($fell(o_selftest_busy) && !o_fault_led);
  cover property ($fell(o_selftest_busy) && o_fault_led);
endmodule : selftest_sva

bind power_on_selftest_sequencer selftest_sva #(.CHIP_PHASE_CYC(CHIP_PHASE_CYC),
  .DISC_PHASE_CYC(DISC_PHASE_CYC)) u_sva (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_disc_stat(i_disc_stat), .o_chip_req(o_chip_req), .o_disc_req(o_disc_req),
  .o_fault_led(o_fault_led), .o_selftest_busy(o_selftest_busy),
  .o_selftest_failed(o_selftest_failed), .o_host_cmd_enable(o_host_cmd_enable));

// ===== testbench/power_on_selftest_sequencer_tb.sv
`timescale 1ns/1ps
module power_on_selftest_sequencer_tb;
  import selftest_pkg::*;
  localparam int CP = 200;
  localparam int DP = 150;
  // {read bad, write bad, failing unit, present, initialized, write protect}
  localparam logic [7:0] TBL [7] = '{8'h38, 8'h3E, 8'h3F, 8'h26, 8'h7E, 8'hBE, 8'h3C};
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  disc_stat_t i_disc_stat = '0;
  unit_rsp_t i_chip_rsp = '0;
  unit_rsp_t i_disc_rsp = '0;
  chip_req_t o_chip_req;
  disc_req_t o_disc_req;
  logic o_fault_led, o_selftest_busy, o_selftest_failed, o_host_cmd_enable;
  int errors = 0;
  int checks = 0;
  int nunit, cdly, ddly, cyc, wr_n, rd_n, bad_unit;
  bit wbad, rbad, dpass;
  logic [31:0] lfsr = 32'h3ABE;

  power_on_selftest_sequencer #(.CHIP_PHASE_CYC(CP), .DISC_PHASE_CYC(DP)) dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_disc_stat(i_disc_stat),
    .i_chip_rsp(i_chip_rsp), .i_disc_rsp(i_disc_rsp), .o_chip_req(o_chip_req),
    .o_disc_req(o_disc_req), .o_fault_led(o_fault_led), .o_selftest_busy(o_selftest_busy),
    .o_selftest_failed(o_selftest_failed), .o_host_cmd_enable(o_host_cmd_enable));

  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ----
  // responders: answer each request three cycles later, past the sync stages
  // ----
  always @(negedge i_sys_clk) begin
    i_chip_rsp <= (cdly == 1) ? '{1'b1, 1'(nunit != bad_unit + 1)} : '0;
    i_disc_rsp <= (ddly == 1) ? '{1'b1, dpass} : '0;
    if (!i_nrst) begin
      nunit <= 0;
      cdly <= 0;
      ddly <= 0;
      cyc <= 0;
      wr_n <= 0;
      rd_n <= 0;
    end else begin
      cyc <= cyc + int'(o_selftest_busy);
      cdly <= o_chip_req.valid ? 3 : (cdly > 0 ? cdly - 1 : 0);
      ddly <= (o_disc_req.write_req || o_disc_req.read_req) ? 3 : (ddly > 0 ? ddly - 1 : 0);
      if (o_chip_req.valid) begin
        check(32'(o_chip_req.unit), 32'(nunit));
        nunit <= nunit + 1;
      end
      if (o_disc_req.write_req || o_disc_req.read_req) begin
        check(32'(o_disc_req.track), 32'h4F);
        check(32'(o_disc_req.read_req), 32'(wr_n));
        dpass <= o_disc_req.write_req ? !wbad : !rbad;
        wr_n <= wr_n + int'(o_disc_req.write_req);
        rd_n <= rd_n + int'(o_disc_req.read_req);
      end
    end
  end

  // ----
  // one power-up with a given disc and fault setup, then model compare
  // ----
  task automatic run(input logic [7:0] v);
    bit expf;
    bit expd;
    int lim;
    int base;
    @(negedge i_sys_clk);
    i_nrst <= 1'b0;
    i_disc_stat = disc_stat_t'(v[2:0]);
    bad_unit = int'(v[5:3]);
    wbad = v[6];
    rbad = v[7];
    repeat (8) @(negedge i_sys_clk);
    check(32'({o_fault_led, o_selftest_busy, o_host_cmd_enable}), 32'h6);
    i_nrst <= 1'b1;
    expd = (v[5:3] > 3'h4) && (v[2:0] == 3'h6);
    expf = (v[5:3] < 3'h5) || (expd && (wbad || rbad));
    base = expd ? CP + DP : CP;
    lim = 0;
    @(negedge i_sys_clk);
    while (o_selftest_busy === 1'b1 && lim < 1000) begin
      @(negedge i_sys_clk);
      lim++;
    end
    check(32'(lim < 1000), 32'h1);
    check(32'({o_fault_led, o_selftest_failed}), 32'({expf, expf}));
    check(32'(o_host_cmd_enable), 32'h1);
    check(32'(wr_n), 32'(expd));
    check(32'(rd_n), 32'(expd && !wbad));
    check(32'(cyc >= base && cyc < base + 24), 32'h1);
  endtask : run

  initial begin
    for (int i = 0; i < 14; i++) begin
      lfsr = lfsr_next(lfsr);
      run(i < 7 ? TBL[i] : lfsr[7:0]);
    end
    report_and_stop();
  end

  // limit sized for fourteen power-ups of under 1000 busy cycles each, the wait limit in run
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule : power_on_selftest_sequencer_tb
